// ### sim/sdd_mod_model.sv
// Behavioural sigma-delta modulator: oversampling clock and one-bit streams
`timescale 1ns/1ps

module sdd_mod_model (
	input wire logic sys_clk,
	input wire logic modFast,
	input wire logic modLevel,
	output logic modClk,
	output logic bitCurrent,
	output logic bitVoltage
);
	// Fractional step keeps the mean rate exact; 25 MHz is no multiple of 2 MHz
	int acc = 0;
	int step;
	assign step = modFast ? 4 : 2;
	initial
	begin
		modClk = 1'b0;
		bitCurrent = 1'b0;
		bitVoltage = 1'b1;
	end
	always @(posedge sys_clk)
	begin
		if (acc + step >= 25)
		begin
			acc <= acc + step - 25;
			modClk <= !modClk;
			// Bits move at the falling edge, so they stand still around the rise
			if (modClk)
			begin
				bitCurrent <= modLevel;
				bitVoltage <= !modLevel;
			end
		end
		else
			acc <= acc + step;
	end
endmodule // sdd_mod_model

// ### sim/tb.sv
// Self-checking bench for the two-channel decimation path
`timescale 1ns/1ps

module tb;
	typedef struct {
		logic fast;
		logic ratio;
		logic [3:0] secLog;
		logic fir;
		logic [3:0] avg;
		logic [2:0] gain;
		logic [2:0] gainExp;
		logic [1:0] vin;
		logic ones;
		logic [15:0] exp;
		int sp;
	} sdd_row_t;
	// Constant streams settle to full scale, so results do not hang on filter phase
	sdd_row_t rows [4] = '{
		'{1'h0, 1'h0, 4'h0, 1'h0, 4'h1, 3'h1, 3'h1, 2'h0, 1'h1, 16'h7FFF, 1600},
		'{1'h0, 1'h1, 4'h0, 1'h0, 4'h2, 3'h2, 3'h2, 2'h2, 1'h0, 16'h8000, 3200},
		'{1'h1, 1'h0, 4'h2, 1'h1, 4'h1, 3'h3, 3'h3, 2'h3, 1'h1, 16'h7FFF, 3200},
		'{1'h1, 1'h1, 4'h1, 1'h1, 4'h1, 3'h7, 3'h4, 2'h1, 1'h0, 16'h8000, 3200}};
	logic sys_clk, rst, modClk, modBitCurrent, modBitVoltage, slowClk;
	logic digSupplyOk, anaSupplyOk, startCmd, stopCmd, cfgWr, modFast, modLevel;
	logic cfgModFast, cfgChopFast, cfgChopOn, cfgFirstRatioCurrent, cfgFirstRatioVoltage;
	logic [3:0] cfgSecondLogCurrent, cfgSecondLogVoltage, cfgAvgLenCurrent, cfgAvgLenVoltage;
	logic cfgPostFirCurrent, cfgPostFirVoltage;
	logic [2:0] cfgGainCurrent, cfgGainVoltage, gainCurrent, gainVoltage;
	logic [1:0] cfgVoltInput, voltInputSel;
	logic [15:0] sampleCurrent, sampleVoltage;
	logic validCurrent, validVoltage, irqOut, chopClk, tempRefPhase, tempSourceEn, ph;
	sdd_pkg::sdd_seq_t seqState;
	int bad_count = 0;
	int n_tests = 0;
	int c1, c2, c3, n;
	localparam logic [15:0] DEF_OUTS = {8'h0, sdd_pkg::DEF_VIN, sdd_pkg::DEF_GAIN, sdd_pkg::DEF_GAIN};

	sdd_mod_model model (.sys_clk(sys_clk), .modFast(modFast), .modLevel(modLevel),
		.modClk(modClk), .bitCurrent(modBitCurrent), .bitVoltage(modBitVoltage));
	sdd_decim_path dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .modClk(modClk),
		.modBitCurrent(modBitCurrent), .modBitVoltage(modBitVoltage), .slowClk(slowClk),
		.digSupplyOk(digSupplyOk), .anaSupplyOk(anaSupplyOk), .startCmd(startCmd),
		.stopCmd(stopCmd), .cfgWr(cfgWr), .cfgModFast(cfgModFast), .cfgChopFast(cfgChopFast),
		.cfgChopOn(cfgChopOn), .cfgFirstRatioCurrent(cfgFirstRatioCurrent),
		.cfgFirstRatioVoltage(cfgFirstRatioVoltage), .cfgSecondLogCurrent(cfgSecondLogCurrent),
		.cfgSecondLogVoltage(cfgSecondLogVoltage), .cfgPostFirCurrent(cfgPostFirCurrent),
		.cfgPostFirVoltage(cfgPostFirVoltage), .cfgAvgLenCurrent(cfgAvgLenCurrent),
		.cfgAvgLenVoltage(cfgAvgLenVoltage), .cfgGainCurrent(cfgGainCurrent),
		.cfgGainVoltage(cfgGainVoltage), .cfgVoltInput(cfgVoltInput),
		.sampleCurrent(sampleCurrent), .sampleVoltage(sampleVoltage),
		.validCurrent(validCurrent), .validVoltage(validVoltage), .irqOut(irqOut),
		.seqState(seqState), .chopClk(chopClk), .gainCurrent(gainCurrent),
		.gainVoltage(gainVoltage), .voltInputSel(voltInputSel),
		.tempRefPhase(tempRefPhase), .tempSourceEn(tempSourceEn));

	always #20 sys_clk = ~sys_clk;
	// Slow oscillator at 1/32 of the system clock keeps sequencer steps short
	always
	begin
		repeat (16) @(posedge sys_clk);
		slowClk <= ~slowClk;
	end

	function logic [15:0] outs;
		outs = {8'h0, voltInputSel, gainCurrent, gainVoltage};
	endfunction
	task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic chkState(input sdd_pkg::sdd_seq_t got, input sdd_pkg::sdd_seq_t exp,
		input string msg);
		chkVal({14'h0, got}, {14'h0, exp}, msg);
	endtask
	task automatic chkRange(input int got, input int lo, input int hi, input string msg);
		n_tests++;
		if (got < lo || got > hi)
		begin
			bad_count++;
			$display("[ERR] %0t %s: %0d not in %0d..%0d", $time, msg, got, lo, hi);
		end
	endtask
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic waitState(input sdd_pkg::sdd_seq_t s, input string msg);
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (seqState !== s && n < 400);
		chkState(seqState, s, msg);
	endtask
	task automatic waitValid(output int c);
		c = 0;
		do
		begin
			tick();
			c++;
		end
		while (validCurrent !== 1'b1 && c < 20000);
	endtask
	task automatic cfgSet(input sdd_row_t r, input logic chopOn, input logic chopFast);
		@(posedge sys_clk);
		cfgWr <= 1'b1;
		cfgModFast <= r.fast;
		cfgChopFast <= chopFast;
		cfgChopOn <= chopOn;
		cfgFirstRatioCurrent <= r.ratio;
		cfgFirstRatioVoltage <= r.ratio;
		cfgSecondLogCurrent <= r.secLog;
		cfgSecondLogVoltage <= r.secLog;
		cfgPostFirCurrent <= r.fir;
		cfgPostFirVoltage <= r.fir;
		cfgAvgLenCurrent <= r.avg;
		cfgAvgLenVoltage <= r.avg;
		cfgGainCurrent <= r.gain;
		cfgGainVoltage <= r.gain;
		cfgVoltInput <= r.vin;
		modFast <= r.fast;
		modLevel <= r.ones;
		@(posedge sys_clk);
		cfgWr <= 1'b0;
	endtask
	task automatic startRun;
		@(posedge sys_clk);
		startCmd <= 1'b1;
		@(posedge sys_clk);
		startCmd <= 1'b0;
		waitState(sdd_pkg::SEQ_RUN, "start");
	endtask
	task automatic stopRun;
		@(posedge sys_clk);
		stopCmd <= 1'b1;
		@(posedge sys_clk);
		stopCmd <= 1'b0;
		waitState(sdd_pkg::SEQ_STOP, "stop");
	endtask
	task automatic measChop(input int half);
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (chopClk !== 1'b1 && n < 20000);
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (chopClk === 1'b1 && n < 20000);
		chkRange(n, half - 26, half + 26, "chopper half period");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		// All tests need about 77,000 cycles; a hang must stop well short of 100,000
		repeat (95000) @(posedge sys_clk);
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial
	begin
		{sys_clk, slowClk, startCmd, stopCmd, cfgWr, modFast, modLevel, digSupplyOk} = '0;
		{cfgModFast, cfgChopFast, cfgChopOn, cfgFirstRatioCurrent, cfgFirstRatioVoltage} = '0;
		{cfgSecondLogCurrent, cfgSecondLogVoltage, cfgAvgLenCurrent, cfgAvgLenVoltage} = '0;
		{cfgPostFirCurrent, cfgPostFirVoltage, cfgGainCurrent, cfgGainVoltage, cfgVoltInput} = '0;
		rst = 1'b1;
		anaSupplyOk = 1'b1;
		repeat (10) tick();
		chkState(seqState, sdd_pkg::SEQ_RESET, "reset state");
		chkVal({12'h0, validCurrent, validVoltage, irqOut, chopClk}, 16'h0, "reset flags");
		chkVal(outs(), 16'h0, "reset gains");
		@(posedge sys_clk);
		rst <= 1'b0;
		startCmd <= 1'b1;
		@(posedge sys_clk);
		startCmd <= 1'b0;
		repeat (150) tick();
		chkState(seqState, sdd_pkg::SEQ_RESET, "digital supply low");
		@(posedge sys_clk);
		digSupplyOk <= 1'b1;
		waitState(sdd_pkg::SEQ_DEFAULTS, "defaults state");
		waitState(sdd_pkg::SEQ_STOP, "stop state");
		chkVal(outs(), DEF_OUTS, "defaults");
		repeat (150) tick();
		chkState(seqState, sdd_pkg::SEQ_STOP, "early start refused");
		$display("power-up test done");
		for (int i = 0; i < 4; i++)
		begin
			cfgSet(rows[i], 1'h0, 1'h0);
			tick();
			chkVal(outs(), {8'h0, rows[i].vin, rows[i].gainExp, rows[i].gainExp}, "cfg");
			startRun();
			waitValid(c1);
			chkRange(c1, 2 * rows[i].sp, 3 * rows[i].sp + 40, "first valid");
			waitValid(c2);
			ph = tempRefPhase;
			waitValid(c3);
			chkRange(c3, rows[i].sp - 2, rows[i].sp + 2, "output spacing");
			chkVal(sampleCurrent, rows[i].exp, "current sample");
			chkVal(sampleVoltage, rows[i].exp ^ 16'hFFFF, "voltage sample");
			chkVal({14'h0, validVoltage, chopClk}, 16'h2, "voltage valid, chop off");
			if (rows[i].vin == sdd_pkg::VIN_EXT_TEMP)
				chkVal({14'h0, tempSourceEn, tempRefPhase ^ ph}, 16'h3, "temp phase");
			n = 0;
			do
			begin
				tick();
				n++;
			end
			while (irqOut === 1'b1 && n < 400);
			chkRange(n, 222, 260, "interrupt width");
			stopRun();
			$display("row %0d done", i);
		end
		startRun();
		cfgSet(rows[0], 1'h0, 1'h0);
		tick();
		chkVal(outs(), {8'h0, 2'h1, 3'h4, 3'h4}, "write in run refused");
		@(posedge sys_clk);
		anaSupplyOk <= 1'b0;
		tick();
		tick();
		chkState(seqState, sdd_pkg::SEQ_RESET, "analog supply loss");
		@(posedge sys_clk);
		anaSupplyOk <= 1'b1;
		waitState(sdd_pkg::SEQ_DEFAULTS, "defaults again");
		waitState(sdd_pkg::SEQ_STOP, "stop again");
		chkVal(outs(), DEF_OUTS, "defaults reloaded");
		$display("supply loss test done");
		startRun();
		measChop(6250);
		stopRun();
		cfgSet(rows[2], 1'h1, 1'h1);
		startRun();
		measChop(3125);
		stopRun();
		$display("chopper test done");
		tally_and_finish();
	end
endmodule // tb

// ### src/sdd_decim_path.sv
// Two-channel sigma-delta decimation path with chopper and power-on sequencer
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------

module sdd_decim_path (
	input logic sys_clk,
	input logic rst,
	input logic clkEn,
	input logic modClk,
	input logic modBitCurrent,
	input logic modBitVoltage,
	input logic slowClk,
	input logic digSupplyOk,
	input logic anaSupplyOk,
	input logic startCmd,
	input logic stopCmd,
	input logic cfgWr,
	input logic cfgModFast,
	input logic cfgChopFast,
	input logic cfgChopOn,
	input logic cfgFirstRatioCurrent,
	input logic cfgFirstRatioVoltage,
	input logic [3:0] cfgSecondLogCurrent,
	input logic [3:0] cfgSecondLogVoltage,
	input logic cfgPostFirCurrent,
	input logic cfgPostFirVoltage,
	input logic [3:0] cfgAvgLenCurrent,
	input logic [3:0] cfgAvgLenVoltage,
	input logic [2:0] cfgGainCurrent,
	input logic [2:0] cfgGainVoltage,
	input logic [1:0] cfgVoltInput,
	output logic [15:0] sampleCurrent,
	output logic [15:0] sampleVoltage,
	output logic validCurrent,
	output logic validVoltage,
	output logic irqOut,
	output sdd_pkg::sdd_seq_t seqState,
	output logic chopClk,
	output logic [2:0] gainCurrent,
	output logic [2:0] gainVoltage,
	output logic [1:0] voltInputSel,
	output logic tempRefPhase,
	output logic tempSourceEn
);
	logic modClkQ;
	logic modFastQ;
	logic chopFastQ;
	logic chopOnQ;
	logic [1:0] firstRatioQ;
	logic [1:0][3:0] secondLogQ;
	logic [1:0] postFirQ;
	logic [1:0][3:0] avgLenQ;
	logic [1:0][2:0] gainQ;
	logic [1:0] voltInQ;
	logic [9:0] chopCntQ;
	logic chopPhaseQ;
	logic chopPrevQ;
	logic [9:0] chopAgeQ;
	logic refPhaseQ;
	logic srcEnQ;
	logic [1:0][15:0] sampleV;
	logic [1:0] validV;

	wire modTick = modClk && !modClkQ;
	wire runQ = seqState == sdd_pkg::SEQ_RUN;
	wire loadDefaults = seqState == sdd_pkg::SEQ_DEFAULTS;
	wire cfgTake = cfgWr && seqState == sdd_pkg::SEQ_STOP;
	wire [1:0] modBitV = {modBitVoltage, modBitCurrent};

	function automatic logic [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'sh00_0000_7FFF)
			return 16'h7FFF;
		if (v < 40'shFF_FFFF_8000)
			return 16'h8000;
		return v[15:0];
	endfunction

	// ----------------------------------------------------------------
	// Sequencer and interrupt
	// ----------------------------------------------------------------
	sdd_seq u_seq (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(clkEn),
		.slowClk(slowClk),
		.digSupplyOk(digSupplyOk),
		.anaSupplyOk(anaSupplyOk),
		.startCmd(startCmd),
		.stopCmd(stopCmd),
		.sampleEvent(|validV),
		.seqState(seqState),
		.irqOut(irqOut)
	);

	// ----------------------------------------------------------------
	// Configuration, writable in stop only
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst || (clkEn && loadDefaults))
		begin
			modFastQ <= sdd_pkg::DEF_MOD_FAST;
			chopFastQ <= sdd_pkg::DEF_CHOP_FAST;
			chopOnQ <= sdd_pkg::DEF_CHOP_ON;
			firstRatioQ <= {2{sdd_pkg::DEF_FIRST_RATIO}};
			secondLogQ <= {2{sdd_pkg::DEF_SECOND_LOG}};
			postFirQ <= {2{sdd_pkg::DEF_POST_FIR}};
			avgLenQ <= {2{sdd_pkg::DEF_AVG_LEN}};
			gainQ <= {2{sdd_pkg::DEF_GAIN}};
			voltInQ <= sdd_pkg::DEF_VIN;
		end
		else if (clkEn && cfgTake)
		begin
			modFastQ <= cfgModFast;
			chopFastQ <= cfgChopFast;
			chopOnQ <= cfgChopOn;
			firstRatioQ <= {cfgFirstRatioVoltage, cfgFirstRatioCurrent};
			secondLogQ <= {cfgSecondLogVoltage, cfgSecondLogCurrent};
			postFirQ <= {cfgPostFirVoltage, cfgPostFirCurrent};
			avgLenQ <= {cfgAvgLenVoltage, cfgAvgLenCurrent};
			// Out-of-range gain codes clamp to the highest gain
			gainQ[0] <= cfgGainCurrent > sdd_pkg::GAIN_MAX ? sdd_pkg::GAIN_MAX : cfgGainCurrent;
			gainQ[1] <= cfgGainVoltage > sdd_pkg::GAIN_MAX ? sdd_pkg::GAIN_MAX : cfgGainVoltage;
			voltInQ <= cfgVoltInput;
		end
	end

	assign gainCurrent = gainQ[0];
	assign gainVoltage = gainQ[1];
	assign voltInputSel = voltInQ;

	// ----------------------------------------------------------------
	// Chopper clock divider
	// ----------------------------------------------------------------
	wire [9:0] chopHalf = modFastQ ?
		(chopFastQ ? sdd_pkg::HALF_2M_4K : sdd_pkg::HALF_2M_2K) :
		(chopFastQ ? sdd_pkg::HALF_1M_4K : sdd_pkg::HALF_1M_2K);
	wire chopWrap = modTick && (chopCntQ == chopHalf - 10'h001);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			modClkQ <= 1'b0;
			chopCntQ <= 10'h000;
			chopPhaseQ <= 1'b0;
		end
		else if (clkEn)
		begin
			modClkQ <= modClk;
			if (!runQ)
			begin
				chopCntQ <= 10'h000;
				chopPhaseQ <= 1'b0;
			end
			else if (modTick)
			begin
				chopCntQ <= chopWrap ? 10'h000 : chopCntQ + 10'h001;
				if (chopWrap && chopOnQ)
					chopPhaseQ <= ~chopPhaseQ;
			end
		end
	end

	assign chopClk = chopPhaseQ;

	// Ticks between chopper edges, for checking only
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			chopPrevQ <= 1'b0;
			chopAgeQ <= 10'h000;
		end
		else if (clkEn)
		begin
			chopPrevQ <= chopPhaseQ;
			if (!runQ || chopPrevQ != chopPhaseQ)
				chopAgeQ <= 10'h000;
			else if (modTick)
				chopAgeQ <= chopAgeQ + 10'h001;
		end
	end

	a_chop_half: assert property (@(posedge sys_clk) disable iff (rst)
		(runQ && chopPrevQ != chopPhaseQ) |-> chopAgeQ == chopHalf)
		else $error("chopper half period wrong");

	a_chop_default: assert property (@(posedge sys_clk) disable iff (rst)
		(loadDefaults && clkEn) |=> chopOnQ)
		else $error("chopper not enabled by defaults");

	a_cfg_frozen: assert property (@(posedge sys_clk) disable iff (rst)
		(runQ && $past(runQ)) |-> ($stable(firstRatioQ) && $stable(secondLogQ)))
		else $error("configuration changed while running");

	// ----------------------------------------------------------------
	// External temperature sequencing on the voltage channel
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			refPhaseQ <= 1'b0;
			srcEnQ <= 1'b0;
		end
		else if (clkEn)
		begin
			// One current source feeds sensor then resistor, so both see the same current
			srcEnQ <= runQ && voltInQ == sdd_pkg::VIN_EXT_TEMP;
			if (!runQ || voltInQ != sdd_pkg::VIN_EXT_TEMP)
				refPhaseQ <= 1'b0;
			else if (validV[1])
				refPhaseQ <= ~refPhaseQ;
		end
	end

	assign tempRefPhase = refPhaseQ;
	assign tempSourceEn = srcEnQ;

	// ----------------------------------------------------------------
	// Per-channel datapath
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < sdd_pkg::NUM_CH; ch++)
	begin : g_ch
		logic signed [22:0] i1Q, i2Q, i3Q, d1Q, d2Q, d3Q;
		logic [6:0] cnt1Q;
		logic s1ValidQ;
		logic s1PhaseQ;
		logic signed [15:0] s1DataQ;
		logic signed [31:0] acc2Q;
		logic [14:0] cnt2Q;
		logic c2ValidQ;
		logic signed [15:0] c2DataQ;
		logic signed [15:0] histQ [0:13];
		logic [1:0] primeQ;
		logic [1:0] seenQ;
		logic [15:0] sampleQ;
		logic validQ;
		logic signed [39:0] avgSum;

		wire signed [22:0] step = modBitV[ch] ? 23'sh000001 : 23'sh7FFFFF;
		wire [6:0] firstLast = firstRatioQ[ch] ?
			sdd_pkg::FIRST_LAST_HIGH : sdd_pkg::FIRST_LAST_LOW;
		wire dec1 = modTick && (cnt1Q == firstLast);
		wire signed [22:0] c1 = i3Q - d1Q;
		wire signed [22:0] c2 = c1 - d2Q;
		wire signed [22:0] c3 = c2 - d3Q;
		wire signed [22:0] c3Sh = firstRatioQ[ch] ?
			(c3 >>> sdd_pkg::FIRST_SH_HIGH) : (c3 >>> sdd_pkg::FIRST_SH_LOW);
		wire signed [16:0] dechop = (chopOnQ && s1PhaseQ) ?
			-17'(s1DataQ) : 17'(s1DataQ);
		wire [14:0] secondMask = 15'((32'h1 << secondLogQ[ch]) - 32'h1);
		wire signed [31:0] acc2Sum = acc2Q + 32'(dechop);
		wire signed [31:0] acc2Out = acc2Sum >>> secondLogQ[ch];
		wire dec2 = s1ValidQ && (cnt2Q == secondMask);
		wire [3:0] avgLen = (avgLenQ[ch] == 4'h0) ? 4'h1 : avgLenQ[ch];
		wire signed [39:0] avgProd = avgSum * 40'(sdd_pkg::AVG_RECIP[avgLen]);
		wire signed [39:0] firSum = 40'(c2DataQ) + 40'sh3 * 40'(histQ[0])
			+ 40'sh3 * 40'(histQ[1]) + 40'(histQ[2]);
		wire [15:0] avgOut = sat16(avgProd >>> sdd_pkg::AVG_SHIFT);
		wire [15:0] firOut = sat16(firSum >>> sdd_pkg::FIR_SHIFT);

		always_comb
		begin
			avgSum = 40'(c2DataQ);
			for (int k = 1; k < sdd_pkg::AVG_MAX; k++)
				if (4'(k) < avgLen)
					avgSum = avgSum + 40'(histQ[k - 1]);
		end

		// Third-order comb: integrators at modulator rate, combs at frame rate
		always_ff @(posedge sys_clk)
		begin
			if (rst || (clkEn && !runQ))
			begin
				{i1Q, i2Q, i3Q, d1Q, d2Q, d3Q} <= '0;
				cnt1Q <= 7'h00;
				s1ValidQ <= 1'b0;
				s1PhaseQ <= 1'b0;
				s1DataQ <= 16'sh0000;
			end
			else if (clkEn)
			begin
				s1ValidQ <= dec1;
				if (modTick)
				begin
					i1Q <= i1Q + step;
					i2Q <= i2Q + i1Q;
					i3Q <= i3Q + i2Q;
					cnt1Q <= dec1 ? 7'h00 : cnt1Q + 7'h01;
				end
				if (dec1)
				begin
					d1Q <= i3Q;
					d2Q <= c1;
					d3Q <= c2;
					s1DataQ <= sat16(40'(c3Sh));
					s1PhaseQ <= chopPhaseQ;
				end
			end
		end

		// Second stage is a block average of 2^n dechopped words
		always_ff @(posedge sys_clk)
		begin
			if (rst || (clkEn && !runQ))
			begin
				acc2Q <= 32'sh0000_0000;
				cnt2Q <= 15'h0000;
				c2ValidQ <= 1'b0;
				c2DataQ <= 16'sh0000;
			end
			else if (clkEn)
			begin
				c2ValidQ <= dec2;
				if (s1ValidQ)
				begin
					acc2Q <= dec2 ? 32'sh0000_0000 : acc2Sum;
					cnt2Q <= dec2 ? 15'h0000 : cnt2Q + 15'h0001;
				end
				if (dec2)
					c2DataQ <= sat16(40'(acc2Out));
			end
		end

		// Post filter; the binomial taps are matched to a 1 kHz output rate
		always_ff @(posedge sys_clk)
		begin
			if (rst)
			begin
				for (int k = 0; k < 14; k++)
					histQ[k] <= 16'sh0000;
				primeQ <= 2'h0;
				seenQ <= 2'h0;
				sampleQ <= 16'h0000;
				validQ <= 1'b0;
			end
			else if (clkEn)
			begin
				validQ <= 1'b0;
				if (!runQ)
				begin
					primeQ <= 2'h0;
					seenQ <= 2'h0;
				end
				else if (c2ValidQ)
				begin
					histQ[0] <= c2DataQ;
					for (int k = 1; k < 14; k++)
						histQ[k] <= histQ[k - 1];
					sampleQ <= postFirQ[ch] ? firOut : avgOut;
					validQ <= primeQ == sdd_pkg::FIRST_SKIP;
					if (primeQ != sdd_pkg::FIRST_SKIP)
						primeQ <= primeQ + 2'h1;
					if (seenQ != sdd_pkg::SEEN_FULL)
						seenQ <= seenQ + 2'h1;
				end
			end
		end

		assign sampleV[ch] = sampleQ;
		assign validV[ch] = validQ;

		a_first_skip: assert property (@(posedge sys_clk) disable iff (rst)
			validQ |-> (seenQ == sdd_pkg::SEEN_FULL && $past(c2ValidQ)))
			else $error("sample flagged valid before two conversions");
	end

	assign sampleCurrent = sampleV[0];
	assign sampleVoltage = sampleV[1];
	assign validCurrent = validV[0];
	assign validVoltage = validV[1];

endmodule // sdd_decim_path

// ### src/sdd_pkg.sv
// Shared constants and types for the sigma-delta decimation path
package sdd_pkg;

	typedef enum logic [1:0] {SEQ_RESET, SEQ_DEFAULTS, SEQ_STOP, SEQ_RUN} sdd_seq_t;

	localparam int NUM_CH = 2;

	// Oversampling and chopper rates
	localparam int MOD_SLOW_HZ = 1000000;
	localparam int MOD_FAST_HZ = 2000000;
	localparam int CHOP_SLOW_HZ = 2000;
	localparam int CHOP_FAST_HZ = 4000;
	localparam logic [9:0] HALF_1M_2K = 10'(MOD_SLOW_HZ / (2 * CHOP_SLOW_HZ));
	localparam logic [9:0] HALF_1M_4K = 10'(MOD_SLOW_HZ / (2 * CHOP_FAST_HZ));
	localparam logic [9:0] HALF_2M_2K = 10'(MOD_FAST_HZ / (2 * CHOP_SLOW_HZ));
	localparam logic [9:0] HALF_2M_4K = 10'(MOD_FAST_HZ / (2 * CHOP_FAST_HZ));

	// First comb stage: last count of a 64 or 128 frame, and output scaling
	localparam logic [6:0] FIRST_LAST_LOW = 7'h3F;
	localparam logic [6:0] FIRST_LAST_HIGH = 7'h7F;
	localparam int FIRST_SH_LOW = 3;
	localparam int FIRST_SH_HIGH = 6;

	// Post filter
	localparam int AVG_MAX = 15;
	localparam int AVG_SHIFT = 16;
	localparam int FIR_SHIFT = 3;
	localparam logic [16:0] AVG_RECIP [0:15] = '{
		17'h10000, 17'h10000, 17'h08000, 17'h05555, 17'h04000, 17'h03333,
		17'h02AAB, 17'h02492, 17'h02000, 17'h01C72, 17'h0199A, 17'h01746,
		17'h01555, 17'h013B1, 17'h01249, 17'h01111};

	// Outputs dropped after start, and slow ticks per interrupt pulse
	localparam logic [1:0] FIRST_SKIP = 2'h2;
	localparam logic [1:0] SEEN_FULL = 2'h3;
	localparam logic [3:0] IRQ_TICKS = 4'h8;

	// Voltage channel input codes
	localparam logic [1:0] VIN_BATT = 2'h0;
	localparam logic [1:0] VIN_EXT_TEMP = 2'h1;
	localparam logic [1:0] VIN_EXT_REF = 2'h2;
	localparam logic [1:0] VIN_INT_TEMP = 2'h3;

	// Gain codes 0..4 select 1, 5, 25, 40, 100
	localparam logic [2:0] GAIN_MAX = 3'h4;

	// Values loaded in the defaults state
	localparam logic DEF_MOD_FAST = 1'b0;
	localparam logic DEF_CHOP_FAST = 1'b0;
	localparam logic DEF_CHOP_ON = 1'b1;
	localparam logic DEF_FIRST_RATIO = 1'b0;
	localparam logic [3:0] DEF_SECOND_LOG = 4'h0;
	localparam logic DEF_POST_FIR = 1'b0;
	localparam logic [3:0] DEF_AVG_LEN = 4'h1;
	localparam logic [2:0] DEF_GAIN = 3'h0;
	localparam logic [1:0] DEF_VIN = VIN_BATT;

endpackage

// ### src/sdd_seq.sv
// Power-on sequencer and sample interrupt, stepped by the slow oscillator
`timescale 1ns/1ps

module sdd_seq (
	input logic sys_clk,
	input logic rst,
	input logic clkEn,
	input logic slowClk,
	input logic digSupplyOk,
	input logic anaSupplyOk,
	input logic startCmd,
	input logic stopCmd,
	input logic sampleEvent,
	output sdd_pkg::sdd_seq_t seqState,
	output logic irqOut
);
	sdd_pkg::sdd_seq_t stateQ;
	sdd_pkg::sdd_seq_t stateD;
	logic slowQ;
	logic startPendQ;
	logic stopPendQ;
	logic [3:0] irqCntQ;
	logic [3:0] irqAgeQ;

	wire slowTick = slowClk && !slowQ;
	wire inStop = stateQ == sdd_pkg::SEQ_STOP;
	wire inRun = stateQ == sdd_pkg::SEQ_RUN;

	assign seqState = stateQ;
	assign irqOut = irqCntQ != 4'h0;

	// ----------------------------------------------------------------
	// State sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		stateD = stateQ;
		if (!anaSupplyOk)
			stateD = sdd_pkg::SEQ_RESET;
		else if (slowTick)
		begin
			case (stateQ)
				sdd_pkg::SEQ_RESET: if (digSupplyOk) stateD = sdd_pkg::SEQ_DEFAULTS;
				sdd_pkg::SEQ_DEFAULTS: stateD = sdd_pkg::SEQ_STOP;
				sdd_pkg::SEQ_STOP: if (startPendQ) stateD = sdd_pkg::SEQ_RUN;
				sdd_pkg::SEQ_RUN: if (stopPendQ) stateD = sdd_pkg::SEQ_STOP;
				default: stateD = sdd_pkg::SEQ_RESET;
			endcase
		end
	end

	// Commands arrive on the fast clock; start waits in stop and stop waits in run for the next slow tick, others are dropped
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			stateQ <= sdd_pkg::SEQ_RESET;
			slowQ <= 1'b0;
			startPendQ <= 1'b0;
			stopPendQ <= 1'b0;
		end
		else if (clkEn)
		begin
			stateQ <= stateD;
			slowQ <= slowClk;
			startPendQ <= inStop && (startCmd || startPendQ);
			stopPendQ <= inRun && (stopCmd || stopPendQ);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pulse, eight slow ticks long
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			irqCntQ <= 4'h0;
			irqAgeQ <= 4'h0;
		end
		else if (clkEn)
		begin
			if (sampleEvent)
				irqCntQ <= sdd_pkg::IRQ_TICKS;
			else if (slowTick && irqOut)
				irqCntQ <= irqCntQ - 4'h1;
			if (sampleEvent)
				irqAgeQ <= 4'h0;
			else if (slowTick && irqOut)
				irqAgeQ <= irqAgeQ + 4'h1;
		end
	end

	a_reset_wait: assert property (@(posedge sys_clk) disable iff (rst)
		(stateQ == sdd_pkg::SEQ_RESET && !digSupplyOk) |=> stateQ == sdd_pkg::SEQ_RESET)
		else $error("sequencer left reset without digital supply");

	a_analog_drop: assert property (@(posedge sys_clk) disable iff (rst)
		(!anaSupplyOk && clkEn) |=> stateQ == sdd_pkg::SEQ_RESET)
		else $error("analog supply loss did not force reset");

	a_defaults_stop: assert property (@(posedge sys_clk) disable iff (rst)
		(stateQ == sdd_pkg::SEQ_DEFAULTS && anaSupplyOk && slowTick && clkEn)
		|=> stateQ == sdd_pkg::SEQ_STOP)
		else $error("defaults state did not move to stop");

	a_start_gate: assert property (@(posedge sys_clk) disable iff (rst)
		(inStop ##1 inRun) |-> $past(startPendQ))
		else $error("run entered without start command");

	a_irq_width: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(irqOut) |-> irqAgeQ == 4'h8)
		else $error("interrupt pulse not eight slow cycles");

endmodule // sdd_seq
